// file: verilog/hwmes_pkg.sv
`default_nettype none
package hwmes_pkg;
   // Register offsets
   localparam logic [7:0] CFG_ADDR = 8'h40;
   localparam logic [7:0] STS1_ADDR = 8'h41;
   localparam logic [7:0] STS2_ADDR = 8'h42;
   localparam logic [7:0] VOLT_EN_ADDR = 8'h7e;
   localparam logic [7:0] FAN_EN_ADDR = 8'h80;
   localparam logic [7:0] TEMP_EN_ADDR = 8'h82;
   localparam logic [7:0] PASS1_ADDR = 8'h8a;
   localparam logic [7:0] PASS2_ADDR = 8'h8b;

   // Reset values
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [15:0] FLAG_RST = 16'h0000;

   // Field positions
   localparam int START_BIT = 0;
   localparam int SUMMARY_BIT = 7;
   localparam int R1_TEMP_BIT = 4;
   localparam int INT_TEMP_BIT = 5;
   localparam int R2_TEMP_BIT = 6;
   localparam int V12_BIT = 8;
   localparam int FAN1_BIT = 10;
   localparam int R1_FAULT_BIT = 14;
   localparam int R2_FAULT_BIT = 15;

   // Implemented flag bits of {second, first} status registers
   localparam logic [15:0] FLAG_IMPL = 16'hdd7f;

   // Limit channel indices and widths
   localparam int N_LIM = 8;
   localparam int N_FAN = 3;
   localparam int RD_W = 8;
   localparam int TACH_W = 16;
   localparam int CH_R1 = 4;
   localparam int CH_R2 = 6;
   localparam int CH_12V = 7;

   // Reading loaded into a faulted remote diode channel
   localparam logic [7:0] FAULT_READING = 8'h80;
endpackage : hwmes_pkg
`default_nettype wire

// file: verilog/hwmes_top.sv
// What this block does
// - First status bit 7 is high while any second-status flag is set.
// - Bit 7 of the first status register ignores software writes.
// - Main power good rising clears both status registers.
// - Voltage flags set when reading at or below low, or above high.
// - Temperature flags set when reading at or below low, or above high.
// - Set flags stay set until written one, enable cleared or main power good rises.
// - Writing one clears a flag only once its condition is gone.
// - Fan flag sets when tach count exceeds its programmed minimum.
// - Writing one clears a fan flag only once the fan is within limit.
// - Diode fault with START forces reading 80h, sets fault and limit flags.
// - Writing one cannot clear diode fault flags while the fault persists.
// - Enables act only with START one; no events without START or enable.
// - With START one, clearing an enable clears its set flag.
// - With START zero, flag kept; later START with enable zero clears it.
// - Toggling START with enable one leaves the flag alone.
// - Group and global enables never alter status flags.
// - Temperature enables live in the register at offset 82h.
// - With START zero no monitoring and no flags set.
`timescale 1ns/10ps
`default_nettype none
module hwmes_top
   import hwmes_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   // Register port
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WR_DATA_I,
   input wire logic WR_STB_I,
   input wire logic RD_STB_I,
   output logic [7:0] RD_DATA_O,
   // Monitor inputs
   input wire logic MAIN_POWER_GOOD_I,
   input wire logic [N_LIM*RD_W-1:0] LIM_READING_I,
   input wire logic [N_LIM*RD_W-1:0] LIM_LOW_I,
   input wire logic [N_LIM*RD_W-1:0] LIM_HIGH_I,
   input wire logic [N_LIM-1:0] LIM_NEW_I,
   input wire logic [N_FAN*TACH_W-1:0] TACH_COUNT_I,
   input wire logic [N_FAN*TACH_W-1:0] TACH_MIN_I,
   input wire logic [N_FAN-1:0] TACH_NEW_I,
   input wire logic [1:0] DIODE_FAULT_I,
   // Outputs
   output logic [7:0] REMOTE1_READING_O,
   output logic [7:0] REMOTE2_READING_O,
   output logic START_O,
   output logic IRQ_O
);

   // Limit check shared by all reading channels
   function automatic logic lim_viol(input logic [7:0] rd,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
      lim_viol = (rd <= lo) || (rd > hi);
   endfunction : lim_viol

   logic [15:0] flag_r, flag_nxt;
   logic start_r, pg_q_r;
   logic [7:0] volt_en_r, fan_en_r, temp_en_r, pass1_r, pass2_r;
   logic [N_LIM-1:0] lim_cond_r, lim_evt, lim_viol_w;
   logic [N_FAN-1:0] fan_cond_r, fan_evt, fan_viol_w;
   logic [7:0] rd_data_r, rd_mux;
   logic [7:0] r1_rd_r, r2_rd_r;
   logic irq_r;
   logic [15:0] en_w, evt_w, cond_w, w1c_w, set_w;
   logic [N_LIM*RD_W-1:0] rd_eff;
   logic [1:0] fault_on;

   // Bus decode
   wire wr_cfg = WR_STB_I && (ADDR_I == CFG_ADDR);
   wire wr_sts1 = WR_STB_I && (ADDR_I == STS1_ADDR);
   wire wr_sts2 = WR_STB_I && (ADDR_I == STS2_ADDR);
   wire wr_ven = WR_STB_I && (ADDR_I == VOLT_EN_ADDR);
   wire wr_fen = WR_STB_I && (ADDR_I == FAN_EN_ADDR);
   wire wr_ten = WR_STB_I && (ADDR_I == TEMP_EN_ADDR);
   wire wr_p1 = WR_STB_I && (ADDR_I == PASS1_ADDR);
   wire wr_p2 = WR_STB_I && (ADDR_I == PASS2_ADDR);
   wire pg_rise = MAIN_POWER_GOOD_I && !pg_q_r;
   wire summary = |flag_r[15:8];

   // Faults only force readings and set flags while monitoring runs
   assign fault_on = DIODE_FAULT_I & {2{start_r}};

   // Reading channel comparators
   genvar c;
   generate
      for (c = 0; c < N_LIM; c = c + 1) begin : g_lim
         wire force_c = (c == CH_R1) ? fault_on[0] :
                        (c == CH_R2) ? fault_on[1] : 1'b0;
         assign rd_eff[c*RD_W +: RD_W] = force_c ? FAULT_READING :
                                         LIM_READING_I[c*RD_W +: RD_W];
         assign lim_viol_w[c] = lim_viol(rd_eff[c*RD_W +: RD_W],
                                         LIM_LOW_I[c*RD_W +: RD_W],
                                         LIM_HIGH_I[c*RD_W +: RD_W]);
         assign lim_evt[c] = LIM_NEW_I[c] && lim_viol_w[c];
      end
   endgenerate

   // Fan tach comparators
   genvar f;
   generate
      for (f = 0; f < N_FAN; f = f + 1) begin : g_fan
         assign fan_viol_w[f] = TACH_COUNT_I[f*TACH_W +: TACH_W] >
                                TACH_MIN_I[f*TACH_W +: TACH_W];
         assign fan_evt[f] = TACH_NEW_I[f] && fan_viol_w[f];
      end
   endgenerate

   // Individual enables per flag bit, temperatures from offset 82h
   assign en_w = {temp_en_r[R2_TEMP_BIT], temp_en_r[R1_TEMP_BIT], 1'b0,
                  fan_en_r[4:2], 1'b0, volt_en_r[4],
                  1'b0, temp_en_r[6:4], volt_en_r[3:0]};

   // Set events per flag bit
   assign evt_w = {fault_on[1], fault_on[0], 1'b0, fan_evt, 1'b0,
                   lim_evt[CH_12V], 1'b0,
                   lim_evt[CH_R2] | fault_on[1], lim_evt[5],
                   lim_evt[CH_R1] | fault_on[0], lim_evt[3:0]};

   // Conditions still active, blocking a write-one clear
   assign cond_w = {DIODE_FAULT_I[1], DIODE_FAULT_I[0], 1'b0, fan_cond_r,
                    1'b0, lim_cond_r[CH_12V], 1'b0,
                    lim_cond_r[CH_R2] | DIODE_FAULT_I[1], lim_cond_r[5],
                    lim_cond_r[CH_R1] | DIODE_FAULT_I[0],
                    lim_cond_r[3:0]};

   // Write-one requests, summary bit excluded
   assign w1c_w = {wr_sts2 ? WR_DATA_I : 8'h00,
                   1'b0, wr_sts1 ? WR_DATA_I[6:0] : 7'h00};
   assign set_w = evt_w & en_w & {16{start_r}};

   // Next value of each flag
   genvar b;
   generate
      for (b = 0; b < 16; b = b + 1) begin : g_flag
         always_comb begin
            if (!FLAG_IMPL[b]) begin
               flag_nxt[b] = 1'b0;
            end else if (pg_rise) begin
               flag_nxt[b] = 1'b0;
            end else if (set_w[b]) begin
               flag_nxt[b] = 1'b1;
            end else if (start_r && !en_w[b]) begin
               flag_nxt[b] = 1'b0;
            end else if (w1c_w[b] && !cond_w[b]) begin
               flag_nxt[b] = 1'b0;
            end else begin
               flag_nxt[b] = flag_r[b];
            end
         end
      end
   endgenerate

   // Read selection
   always_comb begin
      if (ADDR_I == CFG_ADDR) begin
         rd_mux = {7'h00, start_r};
      end else if (ADDR_I == STS1_ADDR) begin
         rd_mux = {summary, flag_r[6:0]};
      end else if (ADDR_I == STS2_ADDR) begin
         rd_mux = flag_r[15:8];
      end else if (ADDR_I == VOLT_EN_ADDR) begin
         rd_mux = volt_en_r;
      end else if (ADDR_I == FAN_EN_ADDR) begin
         rd_mux = fan_en_r;
      end else if (ADDR_I == TEMP_EN_ADDR) begin
         rd_mux = temp_en_r;
      end else if (ADDR_I == PASS1_ADDR) begin
         rd_mux = pass1_r;
      end else if (ADDR_I == PASS2_ADDR) begin
         rd_mux = pass2_r;
      end else begin
         rd_mux = REG_RST;
      end
   end

   // Status flags and power good edge
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         flag_r <= FLAG_RST;
         pg_q_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
         pg_q_r <= MAIN_POWER_GOOD_I;
      end
   end

   // Software control registers
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         start_r <= 1'b0;
         volt_en_r <= REG_RST;
         fan_en_r <= REG_RST;
         temp_en_r <= REG_RST;
         pass1_r <= REG_RST;
         pass2_r <= REG_RST;
      end else begin
         if (wr_cfg) start_r <= WR_DATA_I[START_BIT];
         if (wr_ven) volt_en_r <= WR_DATA_I;
         if (wr_fen) fan_en_r <= WR_DATA_I;
         if (wr_ten) temp_en_r <= WR_DATA_I;
         if (wr_p1) pass1_r <= WR_DATA_I;
         if (wr_p2) pass2_r <= WR_DATA_I;
      end
   end

   // Last comparison result per channel, kept between readings
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         lim_cond_r <= '0;
         fan_cond_r <= '0;
      end else begin
         lim_cond_r <= (LIM_NEW_I & lim_viol_w) |
                       (~LIM_NEW_I & lim_cond_r);
         fan_cond_r <= (TACH_NEW_I & fan_viol_w) |
                       (~TACH_NEW_I & fan_cond_r);
      end
   end

   // Remote diode reading registers, forced on fault
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         r1_rd_r <= REG_RST;
         r2_rd_r <= REG_RST;
      end else begin
         if (LIM_NEW_I[CH_R1] || fault_on[0]) begin
            r1_rd_r <= rd_eff[CH_R1*RD_W +: RD_W];
         end
         if (LIM_NEW_I[CH_R2] || fault_on[1]) begin
            r2_rd_r <= rd_eff[CH_R2*RD_W +: RD_W];
         end
      end
   end

   // Read data and interrupt output
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rd_data_r <= REG_RST;
         irq_r <= 1'b0;
      end else begin
         rd_data_r <= RD_STB_I ? rd_mux : REG_RST;
         irq_r <= |(flag_nxt & {pass2_r, 1'b0, pass1_r[6:0]});
      end
   end

   assign RD_DATA_O = rd_data_r;
   assign REMOTE1_READING_O = r1_rd_r;
   assign REMOTE2_READING_O = r2_rd_r;
   assign START_O = start_r;
   assign IRQ_O = irq_r;

   // Flags allowed to survive this cycle
   wire [15:0] keep_m = start_r ? en_w : 16'hffff;

   // Flag groups that the checks follow one cycle later
   wire [15:0] guard_w = flag_r & cond_w & keep_m;
   wire [15:0] hold_w = flag_r & keep_m & ~w1c_w;
   wire [15:0] en_flag_w = flag_r & en_w;

   // Raw limit checks on the 2.5V and internal channels
   wire volt0_bad = (LIM_READING_I[RD_W-1:0] <= LIM_LOW_I[RD_W-1:0]) ||
                    (LIM_READING_I[RD_W-1:0] > LIM_HIGH_I[RD_W-1:0]);
   wire int_bad =
      (LIM_READING_I[INT_TEMP_BIT*RD_W +: RD_W] <=
       LIM_LOW_I[INT_TEMP_BIT*RD_W +: RD_W]) ||
      (LIM_READING_I[INT_TEMP_BIT*RD_W +: RD_W] >
       LIM_HIGH_I[INT_TEMP_BIT*RD_W +: RD_W]);

   // Checks
   chk_summary_read: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      (RD_STB_I && ADDR_I == STS1_ADDR) |=>
         RD_DATA_O[SUMMARY_BIT] == $past(summary))
      else $error("summary bit does not follow second register");

   chk_summary_ro: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      (wr_sts1 && !pg_rise && set_w[15:8] == 8'h00) |=>
         flag_r[15:8] == ($past(flag_r[15:8]) & $past(keep_m[15:8])))
      else $error("first register write disturbed second register");

   chk_pg_clear: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      pg_rise |=> flag_r == FLAG_RST)
      else $error("power good rise did not clear flags");

   chk_no_set_idle: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      !start_r |=> (flag_r & ~$past(flag_r)) == 16'h0000)
      else $error("flag set while monitoring stopped");

   chk_idle_hold: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      (!start_r && !pg_rise && !wr_sts1 && !wr_sts2) |=>
         flag_r == $past(flag_r))
      else $error("flag changed while stopped without write");

   chk_en_clear: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      start_r |=> (flag_r & ~$past(en_w)) == 16'h0000)
      else $error("disabled flag not cleared");

   chk_w1c_active: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      ((wr_sts1 || wr_sts2) && !pg_rise) |=>
         ($past(guard_w) & ~flag_r) == 16'h0000)
      else $error("active flag cleared by write");

   chk_fan_set: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      (start_r && fan_en_r[2] && fan_evt[0] && !pg_rise) |=>
         flag_r[FAN1_BIT] ##1 (flag_r[FAN1_BIT] || $past(pg_rise) ||
         !$past(fan_en_r[2]) || $past(w1c_w[FAN1_BIT])))
      else $error("fan flag not set");

   chk_fault_reading: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      (start_r && DIODE_FAULT_I[0]) |=>
         REMOTE1_READING_O == FAULT_READING)
      else $error("faulted diode reading not forced");

   chk_volt_set: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      (start_r && volt_en_r[0] && LIM_NEW_I[0] && volt0_bad && !pg_rise)
         |=> flag_r[0])
      else $error("voltage flag not set on limit violation");

   chk_temp_set: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      (start_r && temp_en_r[INT_TEMP_BIT] && LIM_NEW_I[INT_TEMP_BIT] &&
       int_bad && !pg_rise) |=> flag_r[INT_TEMP_BIT])
      else $error("temperature flag not set on limit violation");

   chk_sticky_hold: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      !pg_rise |=> ($past(hold_w) & ~flag_r) == 16'h0000)
      else $error("flag dropped without clear");

   chk_fault_hold: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      (DIODE_FAULT_I[0] && flag_r[R1_FAULT_BIT] &&
       keep_m[R1_FAULT_BIT] && !pg_rise) |=> flag_r[R1_FAULT_BIT])
      else $error("diode fault flag cleared while fault persists");

   chk_fault_flags: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      (start_r && DIODE_FAULT_I[1] && temp_en_r[R2_TEMP_BIT] && !pg_rise)
         |=> (flag_r[R2_FAULT_BIT] && flag_r[R2_TEMP_BIT]))
      else $error("diode fault did not set both flags");

   chk_fan_clear: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      (wr_sts2 && WR_DATA_I[FAN1_BIT-RD_W] && !fan_cond_r[0] &&
       !fan_evt[0] && !pg_rise) |=> !flag_r[FAN1_BIT])
      else $error("fan flag not cleared by write");

   chk_start_keep: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      ($rose(start_r) && !pg_rise && !wr_sts1 && !wr_sts2) |=>
         ($past(en_flag_w) & ~flag_r) == 16'h0000)
      else $error("enabled flag changed by start");

   chk_set_wins: assert property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I)
      (start_r && volt_en_r[0] && LIM_NEW_I[0] && volt0_bad &&
       wr_sts1 && WR_DATA_I[0] && !pg_rise) |=> flag_r[0])
      else $error("write clear beat a new violation");

   cov_volt_set: cover property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I) !flag_r[0] ##1 flag_r[0]);
   cov_w1c_clear: cover property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I) (wr_sts2 && flag_r[FAN1_BIT]) ##1
      !flag_r[FAN1_BIT]);
   cov_fault: cover property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I) flag_r[R2_FAULT_BIT] && flag_r[R2_TEMP_BIT]);
   cov_irq: cover property (@(posedge SYS_CLK_I)
      disable iff (!RESET_N_I) $rose(IRQ_O));

endmodule : hwmes_top
`default_nettype wire

// file: bench/hwmes_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   // Bench signals
   logic clk, rst_n, wr, rd, pg, st, irq;
   logic [7:0] addr, wdata, rdata, lnew, r1, r2;
   logic [63:0] rdg, lo, hi;
   logic [47:0] tc, tm;
   logic [2:0] tnew;
   logic [1:0] flt;
   int errors, checked;

   hwmes_top dut (
      .SYS_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
      .WR_DATA_I(wdata), .WR_STB_I(wr), .RD_STB_I(rd), .RD_DATA_O(rdata),
      .MAIN_POWER_GOOD_I(pg), .LIM_READING_I(rdg), .LIM_LOW_I(lo),
      .LIM_HIGH_I(hi), .LIM_NEW_I(lnew), .TACH_COUNT_I(tc),
      .TACH_MIN_I(tm), .TACH_NEW_I(tnew), .DIODE_FAULT_I(flt),
      .REMOTE1_READING_O(r1), .REMOTE2_READING_O(r2), .START_O(st),
      .IRQ_O(irq));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Verdict and end of run
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : final_report

   // Value comparison
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp8

   // One-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read strobe, data taken in the following cycle
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 cmp8(rdata, exp);
   endtask : chk_reg

   // New reading on one limit channel
   task automatic lim(input int ch, input logic [7:0] v);
      @(posedge clk);
      rdg[ch*8 +: 8] <= v;
      lnew[ch] <= 1'b1;
      @(posedge clk);
      lnew <= 8'h00;
      @(posedge clk);
   endtask : lim

   // New tach count on one fan
   task automatic tach(input int f, input logic [15:0] v);
      @(posedge clk);
      tc[f*16 +: 16] <= v;
      tnew[f] <= 1'b1;
      @(posedge clk);
      tnew <= 3'h0;
      @(posedge clk);
   endtask : tach

   // Reset state and unmapped address
   task automatic t_reset();
      chk_reg(8'h41, 8'h00);
      chk_reg(8'h42, 8'h00);
      chk_reg(8'h55, 8'h00);
      cmp8({7'h00, irq}, 8'h00);
   endtask : t_reset

   // Voltage and temperature flags, boundaries and write-one clear
   task automatic t_limits();
      wr_reg(8'h40, 8'h01);
      wr_reg(8'h7e, 8'h1f);
      wr_reg(8'h82, 8'h70);
      wr_reg(8'h8a, 8'h7f);
      wr_reg(8'h8b, 8'hff);
      for (int i = 0; i < 4; i++) lim(i, 8'h40);
      chk_reg(8'h41, 8'h0f);
      lim(5, 8'hc0);
      chk_reg(8'h41, 8'h0f);
      lim(5, 8'hc1);
      lim(4, 8'h3f);
      lim(6, 8'h00);
      lim(7, 8'hc1);
      chk_reg(8'h42, 8'h01);
      chk_reg(8'h41, 8'hff);
      cmp8({7'h00, irq}, 8'h01);
      wr_reg(8'h41, 8'h7f);
      chk_reg(8'h41, 8'hff);
      for (int i = 0; i < 8; i++) lim(i, 8'h80);
      chk_reg(8'h41, 8'hff);
      wr_reg(8'h41, 8'h00);
      chk_reg(8'h41, 8'hff);
      wr_reg(8'h41, 8'h0f);
      chk_reg(8'h41, 8'hf0);
      wr_reg(8'h41, 8'h80);
      chk_reg(8'h41, 8'hf0);
      wr_reg(8'h42, 8'h01);
      chk_reg(8'h41, 8'h70);
      wr_reg(8'h8a, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      cmp8({7'h00, irq}, 8'h00);
      wr_reg(8'h8a, 8'h70);
      repeat (2) @(posedge clk);
      #1;
      cmp8({7'h00, irq}, 8'h01);
      wr_reg(8'h41, 8'h70);
      chk_reg(8'h41, 8'h00);
      cmp8({7'h00, irq}, 8'h00);
   endtask : t_limits

   // Fan slow flags
   task automatic t_fan();
      wr_reg(8'h80, 8'h1c);
      tach(0, 16'h1000);
      chk_reg(8'h42, 8'h00);
      for (int f = 0; f < 3; f++) tach(f, 16'h1001);
      chk_reg(8'h42, 8'h1c);
      chk_reg(8'h41, 8'h80);
      wr_reg(8'h42, 8'h1c);
      chk_reg(8'h42, 8'h1c);
      for (int f = 0; f < 3; f++) tach(f, 16'h0800);
      wr_reg(8'h42, 8'h04);
      chk_reg(8'h42, 8'h18);
      wr_reg(8'h42, 8'h18);
      chk_reg(8'h42, 8'h00);
      chk_reg(8'h41, 8'h00);
   endtask : t_fan

   // Remote diode faults
   task automatic t_fault();
      lim(4, 8'h90);
      lim(6, 8'h90);
      cmp8(r1, 8'h90);
      cmp8(r2, 8'h90);
      @(posedge clk);
      flt <= 2'b11;
      repeat (3) @(posedge clk);
      #1;
      cmp8(r1, 8'h80);
      cmp8(r2, 8'h80);
      chk_reg(8'h42, 8'hc0);
      chk_reg(8'h41, 8'hd0);
      wr_reg(8'h42, 8'hc0);
      chk_reg(8'h42, 8'hc0);
      @(posedge clk);
      flt <= 2'b00;
      lim(4, 8'h80);
      lim(6, 8'h80);
      wr_reg(8'h42, 8'hc0);
      wr_reg(8'h41, 8'h50);
      chk_reg(8'h42, 8'h00);
      chk_reg(8'h41, 8'h00);
   endtask : t_fault

   // Individual enables against START
   task automatic t_enable();
      lim(0, 8'h00);
      wr_reg(8'h7e, 8'h1e);
      chk_reg(8'h41, 8'h00);
      lim(0, 8'h00);
      chk_reg(8'h41, 8'h00);
      wr_reg(8'h7e, 8'h1f);
      lim(0, 8'h00);
      wr_reg(8'h40, 8'h00);
      #1;
      cmp8({7'h00, st}, 8'h00);
      chk_reg(8'h41, 8'h01);
      lim(1, 8'h00);
      chk_reg(8'h41, 8'h01);
      wr_reg(8'h40, 8'h01);
      chk_reg(8'h41, 8'h01);
      wr_reg(8'h40, 8'h00);
      wr_reg(8'h7e, 8'h1e);
      chk_reg(8'h41, 8'h01);
      wr_reg(8'h40, 8'h01);
      chk_reg(8'h41, 8'h00);
   endtask : t_enable

   // Power good rise clears both status registers
   task automatic t_power();
      wr_reg(8'h7e, 8'h1f);
      lim(0, 8'h00);
      lim(7, 8'h00);
      chk_reg(8'h42, 8'h01);
      chk_reg(8'h41, 8'h81);
      @(posedge clk);
      pg <= 1'b1;
      chk_reg(8'h41, 8'h00);
      chk_reg(8'h42, 8'h00);
   endtask : t_power

   // Main sequence
   initial begin
      errors = 0;
      checked = 0;
      rst_n = 1'b0;
      {wr, rd, pg, addr, wdata, lnew, tnew, flt} = '0;
      rdg = {8{8'h80}};
      lo = {8{8'h40}};
      hi = {8{8'hc0}};
      tc = {3{16'h0800}};
      tm = {3{16'h1000}};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_limits();
      t_fan();
      t_fault();
      t_enable();
      t_power();
      final_report();
   end

   // Watchdog against a hang
   initial begin
      #100000;
      errors++;
      final_report();
   end
endmodule : testbench
`default_nettype wire
